// file: bench/lcs_line_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module lcs_line_ctrl_tb;
    import lcs_pkg::*;
    logic clock = 1'b0, rst = 1'b1, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = 2'b00;
    logic rx_miss = 1'b0, tx_busy = 1'b0, pol_rev = 1'b0, rx_act = 1'b0, rx_dat = 1'b0;
    logic link_pulse, collision;
    logic rx_pass, tx_allow, attach, tp_sel, tp_tx_en, mod_bo, pol_fix, two_def, lo_sq;
    logic miss_irq, col_irq;
    logic [15:0] v;
    int fail_count = 0, compares = 0, irq_n = 0, col_n = 0;
    always #10 clock = ~clock;
    always @(posedge clock) if (miss_irq === 1'b1) irq_n++;
    always @(posedge clock) if (col_irq === 1'b1) col_n++;
    lcs_line_model i_lcs_line_model (.clock(clock), .link_pulse(link_pulse),
        .collision(collision));
    lcs_line_ctrl #(.LINK_FAIL_CYCLES_P(50)) i_lcs_line_ctrl (.clock(clock), .rst(rst),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_miss_event(rx_miss), .tx_in_progress(tx_busy),
        .phy_rx_active(rx_act), .phy_collision(collision), .phy_link_pulse(link_pulse),
        .phy_rx_data(rx_dat), .phy_polarity_reversed(pol_rev), .rx_pass(rx_pass),
        .tx_allow(tx_allow), .attachment_selected(attach), .twisted_pair_selected(tp_sel),
        .twisted_pair_tx_enable(tp_tx_en), .modified_backoff(mod_bo), .polarity_correct(pol_fix),
        .two_part_deferral(two_def), .low_squelch(lo_sq), .miss_wrap_irq(miss_irq),
        .collision_wrap_irq(col_irq));
    // Single AHB transfer; ev raises a missed frame alongside the address phase
    task automatic xfer(input logic [11:0] a, input logic wr, input logic [15:0] d,
            input logic ev, output logic [15:0] q);
        @(posedge clock);
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        rx_miss <= ev;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'b00;
        rx_miss <= 1'b0;
        hwdata <= {16'h0, d};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        q = hrdata[15:0];
    endtask
    task automatic miss(input int n);
        @(posedge clock);
        rx_miss <= 1'b1;
        repeat (n) @(posedge clock);
        rx_miss <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic end_sim();
        if (fail_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // Reset values and fixed patterns
        xfer(ADDR_LINE_CONTROL, 0, 0, 0, v); `CHK(v, 16'h0013)
        `CHK({hresp, rx_pass, tx_allow, attach, tp_sel}, 5'b00001)
        `CHK({mod_bo, two_def, lo_sq, tp_tx_en}, 4'b0100)
        xfer(ADDR_MISSED_FRAME, 0, 0, 0, v); `CHK(v, 16'h0010)
        xfer(ADDR_COLLISION, 0, 0, 0, v); `CHK(v, 16'h0012)
        xfer(ADDR_LINE_STATUS, 0, 0, 0, v); `CHK(v[5:0], 6'h14)
        `CHK(v[7], 1'b0)
        // Half-way warning, clear on read, wrap
        xfer(ADDR_IRQ_CONFIG, 1, 16'h3000, 0, v);
        miss(511); `CHK(irq_n, 0)
        miss(1); `CHK(irq_n, 1)
        xfer(ADDR_MISSED_FRAME, 0, 0, 0, v); `CHK(v, 16'h8010)
        xfer(ADDR_MISSED_FRAME, 0, 0, 1, v); `CHK(v, 16'h0010)
        xfer(ADDR_MISSED_FRAME, 0, 0, 0, v); `CHK(v, 16'h0050)
        miss(1024);
        xfer(ADDR_MISSED_FRAME, 0, 0, 0, v); `CHK(v, 16'h0010)
        // Collisions only count while transmitting
        i_lcs_line_model.burst(1);
        tx_busy <= 1'b1;
        rx_act <= 1'b1;
        repeat (3) i_lcs_line_model.burst(1);
        rx_act <= 1'b0;
        tx_busy <= 1'b0;
        xfer(ADDR_COLLISION, 0, 0, 0, v); `CHK(v, 16'h0112)
        xfer(ADDR_COLLISION, 0, 0, 0, v); `CHK(v, 16'h0012)
        // Collision half-way warning
        tx_busy <= 1'b1;
        repeat (512) i_lcs_line_model.burst(1);
        tx_busy <= 1'b0;
        `CHK(col_n, 1)
        xfer(ADDR_COLLISION, 0, 0, 0, v); `CHK(v, 16'h8012)
        // Enables and forced attachment port
        pol_rev <= 1'b1;
        xfer(ADDR_LINE_CONTROL, 1, 16'h01c0, 0, v);
        xfer(ADDR_LINE_CONTROL, 0, 0, 0, v); `CHK(v, 16'h01d3)
        repeat (3) @(posedge clock);
        `CHK(rx_pass, 1'b1)
        `CHK(tx_allow, 1'b1)
        `CHK(attach, 1'b1)
        `CHK(pol_fix, 1'b1)
        xfer(ADDR_LINE_STATUS, 0, 0, 0, v); `CHK(v[9:8], 2'b01)
        `CHK(v[12], 1'b0)
        // Receive gate waits for the frame in progress to end
        rx_dat <= 1'b1;
        repeat (4) @(posedge clock);
        rx_dat <= 1'b0;
        xfer(ADDR_LINE_CONTROL, 1, 16'h0180, 0, v);
        xfer(ADDR_LINE_STATUS, 0, 0, 0, v); `CHK(v[14], 1'b1)
        `CHK(rx_pass, 1'b1)
        repeat (12) @(posedge clock);
        `CHK(rx_pass, 1'b0)
        xfer(ADDR_LINE_STATUS, 0, 0, 0, v); `CHK(v[14], 1'b0)
        // Backoff, deferral, polarity and squelch options
        xfer(ADDR_LINE_CONTROL, 1, 16'h7800, 0, v);
        repeat (2) @(posedge clock);
        `CHK({mod_bo, lo_sq}, 2'b11)
        `CHK(two_def, 1'b0)
        `CHK(pol_fix, 1'b0)
        // Twisted pair follows link activity
        xfer(ADDR_LINE_CONTROL, 1, 16'h0000, 0, v);
        i_lcs_line_model.burst(0);
        xfer(ADDR_LINE_STATUS, 0, 0, 0, v); `CHK(v[9:7], 3'b101)
        `CHK(tp_tx_en, 1'b1)
        `CHK(rx_pass, 1'b0)
        repeat (60) @(posedge clock);
        xfer(ADDR_LINE_STATUS, 0, 0, 0, v); `CHK(v[7], 1'b0)
        `CHK(tp_tx_en, 1'b0)
        // Link test disable and automatic port choice without link
        xfer(ADDR_LINK_TEST, 1, 16'h0080, 0, v);
        repeat (2) @(posedge clock);
        `CHK(tp_tx_en, 1'b1)
        xfer(ADDR_LINE_CONTROL, 1, 16'h0200, 0, v);
        repeat (2) @(posedge clock);
        `CHK({attach, tp_sel, tp_tx_en}, 3'b100)
        end_sim();
    end
endmodule
`default_nettype wire

// file: bench/lcs_line_model.sv
`timescale 1ns/10ps
`default_nettype none
// Line front end: link pulses and collision bursts, pins low when idle
module lcs_line_model (
    // Clock
    input wire logic clock,
    // Pins towards the block
    output logic link_pulse,
    output logic collision
);
    initial begin
        link_pulse = 1'b0;
        collision = 1'b0;
    end
    // One burst of four cycles on the chosen pin, then four idle cycles
    task automatic burst(input bit col);
        @(posedge clock);
        if (col) collision <= 1'b1; else link_pulse <= 1'b1;
        repeat (4) @(posedge clock);
        collision <= 1'b0;
        link_pulse <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// file: rtl/lcs_dummy_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: rtl/lcs_line_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Ten-bit clear-on-read event counter with half-way pulse
module lcs_wrap_counter #(
    parameter int unsigned WIDTH = 10,
    parameter logic [WIDTH-1:0] HALF = 10'h1ff
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Events and control
    input wire logic inc,
    input wire logic clear,
    input wire logic irq_enable,
    // Results
    output logic [WIDTH-1:0] count,
    output logic wrap_pulse
);
    // Count; a clear keeps a coincident event, top value rolls to zero
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= '0;
        end else if (clear) begin
            count <= inc ? WIDTH'(1) : '0; // RULE22
        end else if (inc) begin
            count <= WIDTH'(count + WIDTH'(1)); // RULE3 RULE8
        end
    end

    // One-cycle pulse as the count crosses from HALF to HALF+1
    always_ff @(posedge clock) begin
        if (rst) begin
            wrap_pulse <= 1'b0;
        end else begin
            wrap_pulse <= irq_enable && inc && !clear && (count == HALF); // RULE2 RULE7
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Line configuration, line status and statistics counters
module lcs_line_ctrl
    import lcs_pkg::*;
#(
    parameter int unsigned LINK_FAIL_CYCLES_P = lcs_pkg::LINK_FAIL_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // MAC engine, same clock
    input wire logic rx_miss_event,
    input wire logic tx_in_progress,
    // Line front end pins, asynchronous
    input wire logic phy_rx_active,
    input wire logic phy_collision,
    input wire logic phy_link_pulse,
    input wire logic phy_rx_data,
    input wire logic phy_polarity_reversed,
    // Frame gating towards the MAC
    output logic rx_pass,
    output logic tx_allow,
    // Port and line options
    output logic attachment_selected,
    output logic twisted_pair_selected,
    output logic twisted_pair_tx_enable,
    output logic modified_backoff,
    output logic polarity_correct,
    output logic two_part_deferral,
    output logic low_squelch,
    // Half-way counter warnings
    output logic miss_wrap_irq,
    output logic collision_wrap_irq
);
    import lcs_pkg::*;

    localparam logic [LINK_CNT_W-1:0] LINK_LIMIT = LINK_CNT_W'(LINK_FAIL_CYCLES_P);
    localparam logic [HOLD_CNT_W-1:0] HOLD_LOAD = HOLD_CNT_W'(CARRIER_HOLD_CYCLES);

    logic [15:0] line_control_reg;
    logic [15:0] irq_config_reg;
    logic [15:0] link_test_reg;
    logic [15:0] line_control_now;
    logic [15:0] irq_config_now;
    logic [15:0] link_test_now;
    logic [15:0] read_value;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic wr_pending_reg;
    logic addr_phase;
    logic rd_take;
    logic rd_phase_reg;
    logic [ADDR_W-1:0] rd_addr_reg;
    logic [PIN_COUNT-1:0] pin_meta_reg;
    logic [PIN_COUNT-1:0] pin_sync_reg;
    logic [PIN_COUNT-1:0] pin_prev_reg;
    logic [LINK_CNT_W-1:0] link_cnt_reg;
    logic link_good_reg;
    logic [HOLD_CNT_W-1:0] hold_cnt_reg;
    logic carrier_reg;
    logic collision_event;
    logic data_rise;
    logic link_activity;
    logic [COUNT_W-1:0] miss_count;
    logic [COUNT_W-1:0] col_count;
    logic miss_clear;
    logic col_clear;
    lcs_port_t port_next;
    logic tbt_tx_next;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: a transfer is taken in its address phase
    assign addr_phase = hsel && htrans[1] && hready;
    assign rd_take = addr_phase && !hwrite;
    assign miss_clear = rd_take && (haddr[ADDR_W-1:0] == ADDR_MISSED_FRAME); // RULE4
    assign col_clear = rd_take && (haddr[ADDR_W-1:0] == ADDR_COLLISION); // RULE9

    // Write address held into the data phase
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pending_reg <= addr_phase && hwrite;
            wr_addr_reg <= haddr[ADDR_W-1:0];
        end
    end

    // Register views including a write still in its data phase
    always_comb begin
        line_control_now = line_control_reg;
        irq_config_now = irq_config_reg;
        link_test_now = link_test_reg;
        if (wr_pending_reg && wr_addr_reg == ADDR_LINE_CONTROL) begin
            line_control_now = (hwdata[15:0] & MASK_LINE_CONTROL) | RST_LINE_CONTROL;
        end
        if (wr_pending_reg && wr_addr_reg == ADDR_IRQ_CONFIG) begin
            irq_config_now = (hwdata[15:0] & MASK_IRQ_CONFIG) | RST_IRQ_CONFIG;
        end
        if (wr_pending_reg && wr_addr_reg == ADDR_LINK_TEST) begin
            link_test_now = (hwdata[15:0] & MASK_LINK_TEST) | RST_LINK_TEST;
        end
    end

    // Writable registers, fixed bits forced on each write
    always_ff @(posedge clock) begin
        if (rst) begin
            line_control_reg <= RST_LINE_CONTROL;
            irq_config_reg <= RST_IRQ_CONFIG;
            link_test_reg <= RST_LINK_TEST;
        end else begin
            line_control_reg <= line_control_now;
            irq_config_reg <= irq_config_now;
            link_test_reg <= link_test_now;
        end
    end

    // Read multiplexer; unmapped words read zero
    always_comb begin
        read_value = 16'h0000;
        case (haddr[ADDR_W-1:0])
            ADDR_LINE_CONTROL: read_value = line_control_now;
            ADDR_IRQ_CONFIG: read_value = irq_config_now;
            ADDR_LINK_TEST: read_value = link_test_now;
            ADDR_MISSED_FRAME: read_value = {miss_count, ID_MISSED_FRAME}; // RULE5
            ADDR_COLLISION: read_value = {col_count, ID_COLLISION}; // RULE9
            ADDR_LINE_STATUS: begin
                read_value = {10'h000, ID_LINE_STATUS}; // RULE21
                read_value[LS_LINK_GOOD] = link_good_reg;
                read_value[LS_ATTACHMENT_IN_USE] = attachment_selected; // RULE18
                read_value[LS_TWISTED_PAIR_IN_USE] = twisted_pair_selected; // RULE18
                read_value[LS_POLARITY_NORMAL] = !pin_sync_reg[PIN_POL_REVERSED]; // RULE19
                read_value[LS_CARRIER_ACTIVE] = carrier_reg;
            end
            default: read_value = 16'h0000;
        endcase
    end

    // Read data captured at the address phase, shown in the data phase
    always_ff @(posedge clock) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
            rd_phase_reg <= 1'b0;
            rd_addr_reg <= '0;
        end else begin
            hrdata <= rd_take ? {16'h0000, read_value} : 32'h0000_0000;
            rd_phase_reg <= rd_take;
            rd_addr_reg <= haddr[ADDR_W-1:0];
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge clock) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for the front end pins
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            pin_prev_reg <= '0;
        end else begin
            pin_meta_reg <= {phy_polarity_reversed, phy_rx_data, phy_link_pulse,
                             phy_collision, phy_rx_active};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Collision: receive pair or collision pair going active while sending
    assign collision_event = tx_in_progress &&
        ((pin_sync_reg[PIN_RX_ACTIVE] && !pin_prev_reg[PIN_RX_ACTIVE]) ||
         (pin_sync_reg[PIN_COLLISION] && !pin_prev_reg[PIN_COLLISION])); // RULE6
    assign data_rise = pin_sync_reg[PIN_RX_DATA] && !pin_prev_reg[PIN_RX_DATA];
    assign link_activity = (pin_sync_reg[PIN_LINK_PULSE] && !pin_prev_reg[PIN_LINK_PULSE]) ||
        pin_sync_reg[PIN_RX_ACTIVE];

    // Missed frame and collision counters
    lcs_wrap_counter #(.WIDTH(COUNT_W), .HALF(COUNT_HALF)) u_miss (
        .clock(clock),
        .rst(rst),
        .inc(rx_miss_event), // RULE1
        .clear(miss_clear),
        .irq_enable(irq_config_reg[IC_MISS_WRAP_IRQ_ENABLE]),
        .count(miss_count),
        .wrap_pulse(miss_wrap_irq)
    );

    lcs_wrap_counter #(.WIDTH(COUNT_W), .HALF(COUNT_HALF)) u_col (
        .clock(clock),
        .rst(rst),
        .inc(collision_event),
        .clear(col_clear),
        .irq_enable(irq_config_reg[IC_COLLISION_WRAP_IRQ_ENABLE]),
        .count(col_count),
        .wrap_pulse(collision_wrap_irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link monitor: idle time counted, a link pulse or receive activity restarts it
    always_ff @(posedge clock) begin
        if (rst) begin
            link_cnt_reg <= '0;
            link_good_reg <= 1'b0;
        end else if (link_activity) begin
            link_cnt_reg <= '0;
            link_good_reg <= 1'b1;
        end else if (link_cnt_reg != LINK_LIMIT) begin
            link_cnt_reg <= LINK_CNT_W'(link_cnt_reg + LINK_CNT_W'(1));
        end else begin
            link_good_reg <= 1'b0; // RULE17
        end
    end

    // Carrier held a short time after each rising edge of recovered data
    always_ff @(posedge clock) begin
        if (rst) begin
            hold_cnt_reg <= '0;
            carrier_reg <= 1'b0;
        end else if (data_rise) begin
            hold_cnt_reg <= HOLD_LOAD;
            carrier_reg <= 1'b1;
        end else if (hold_cnt_reg != '0) begin
            hold_cnt_reg <= HOLD_CNT_W'(hold_cnt_reg - HOLD_CNT_W'(1));
        end else begin
            carrier_reg <= 1'b0; // RULE20
        end
    end

    // Frame gates sample the enables only between frames
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_pass <= 1'b0;
            tx_allow <= 1'b0;
        end else begin
            if (!carrier_reg) begin
                rx_pass <= line_control_reg[LC_RECEIVER_ENABLE]; // RULE10
            end
            if (!tx_in_progress) begin
                tx_allow <= line_control_reg[LC_TRANSMITTER_ENABLE]; // RULE11
            end
        end
    end

    // Port choice; automatic mode prefers twisted pair while link is good
    always_comb begin
        port_next = LCS_PORT_TWISTED_PAIR;
        if (line_control_reg[LC_ATTACHMENT_PORT_ONLY]) begin
            port_next = LCS_PORT_ATTACHMENT;
        end else if (line_control_reg[LC_AUTO_PORT_SELECT] && !link_good_reg) begin
            port_next = LCS_PORT_ATTACHMENT;
        end
        tbt_tx_next = (port_next == LCS_PORT_TWISTED_PAIR) &&
            (link_good_reg || link_test_reg[LT_LINK_TEST_DISABLE]);
    end

    // Port and option outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            attachment_selected <= 1'b0;
            twisted_pair_selected <= 1'b1;
            twisted_pair_tx_enable <= 1'b0;
            modified_backoff <= 1'b0;
            polarity_correct <= 1'b0;
            two_part_deferral <= 1'b1;
            low_squelch <= 1'b0;
        end else begin
            attachment_selected <= (port_next == LCS_PORT_ATTACHMENT); // RULE12
            twisted_pair_selected <= (port_next == LCS_PORT_TWISTED_PAIR); // RULE12
            twisted_pair_tx_enable <= tbt_tx_next; // RULE13
            modified_backoff <= line_control_reg[LC_MODIFIED_BACKOFF_ENABLE]; // RULE14
            polarity_correct <= pin_sync_reg[PIN_POL_REVERSED] &&
                !line_control_reg[LC_POLARITY_FIX_DISABLE]; // RULE15
            two_part_deferral <= !line_control_reg[LC_TWO_STAGE_DEFERRAL_DISABLE]; // RULE16
            low_squelch <= line_control_reg[LC_LOW_SQUELCH_SELECT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_miss_cross;
        rx_miss_event && !miss_clear && miss_count == COUNT_HALF;
    endsequence

    sequence s_col_cross;
        collision_event && !col_clear && col_count == COUNT_HALF;
    endsequence

    a_miss_counts: assert property (rx_miss_event && !miss_clear |=> // RULE1
        miss_count == COUNT_W'($past(miss_count) + COUNT_W'(1)))
        else $error("missed frame not counted");
    a_miss_wrap_irq: assert property ( // RULE2
        s_miss_cross ##0 irq_config_reg[IC_MISS_WRAP_IRQ_ENABLE] |=> miss_wrap_irq)
        else $error("miss half-way interrupt missing");
    a_miss_top_wrap: assert property ( // RULE3
        rx_miss_event && !miss_clear && miss_count == COUNT_TOP |=> miss_count == '0)
        else $error("miss counter did not wrap");
    a_miss_read_clear: assert property (miss_clear |=> // RULE4 RULE22
        miss_count == ($past(rx_miss_event) ? COUNT_W'(1) : '0))
        else $error("miss counter not cleared by read");
    a_miss_read_id: assert property ( // RULE5
        rd_phase_reg && rd_addr_reg == ADDR_MISSED_FRAME |-> hrdata[5:0] == ID_MISSED_FRAME)
        else $error("miss counter id pattern wrong");
    a_col_counts: assert property (collision_event && !col_clear |=> // RULE6
        col_count == COUNT_W'($past(col_count) + COUNT_W'(1)))
        else $error("collision not counted");
    a_col_wrap_irq: assert property ( // RULE7
        s_col_cross ##0 irq_config_reg[IC_COLLISION_WRAP_IRQ_ENABLE] |=> collision_wrap_irq)
        else $error("collision half-way interrupt missing");
    a_col_top_wrap: assert property ( // RULE8
        collision_event && !col_clear && col_count == COUNT_TOP |=> col_count == '0)
        else $error("collision counter did not wrap");
    a_col_read_clear: assert property (col_clear |=> // RULE9
        col_count == ($past(collision_event) ? COUNT_W'(1) : '0) ##0
        hrdata[5:0] == ID_COLLISION)
        else $error("collision read wrong");
    a_rx_frame_hold: assert property (carrier_reg && $past(carrier_reg) |-> // RULE10
        $stable(rx_pass))
        else $error("receive gate changed inside a frame");
    a_tx_frame_hold: assert property (tx_in_progress ##1 tx_in_progress |-> // RULE11
        $stable(tx_allow))
        else $error("transmit gate changed inside a frame");
    a_port_attach: assert property ( // RULE12
        line_control_reg[LC_ATTACHMENT_PORT_ONLY] |=> attachment_selected && !twisted_pair_selected)
        else $error("attachment port not selected");
    a_tbt_gate: assert property (twisted_pair_tx_enable |-> // RULE13
        $past(link_good_reg) || $past(link_test_reg[LT_LINK_TEST_DISABLE]))
        else $error("twisted pair transmitter enabled without link");
    a_link_idle: assert property (link_good_reg && !link_activity && // RULE17
        link_cnt_reg == LINK_LIMIT |=> !link_good_reg)
        else $error("link good did not drop after idle time");
    a_status_id: assert property ( // RULE21 RULE18
        rd_phase_reg && rd_addr_reg == ADDR_LINE_STATUS |-> hrdata[5:0] == ID_LINE_STATUS &&
        hrdata[LS_ATTACHMENT_IN_USE] != hrdata[LS_TWISTED_PAIR_IN_USE])
        else $error("line status id or port bits wrong");
    a_carrier_hold: assert property (data_rise |=> carrier_reg [*8]) // RULE20
        else $error("carrier dropped too early");
endmodule

`default_nettype wire

// file: rtl/lcs_pkg.sv
// Function
// [RULE1] Count frames dropped for lack of buffer
// [RULE2] Miss interrupt on step 1FFh to 200h
// [RULE3] Miss count wraps to zero after 3FFh
// [RULE4] Reading miss counter returns count, then clears
// [RULE5] Miss counter low bits read 010000
// [RULE6] Count collisions during transmission in progress
// [RULE7] Collision interrupt on step 1FFh to 200h
// [RULE8] Collision count wraps to zero after 3FFh
// [RULE9] Collision read clears; low bits read 010010
// [RULE10] Receiver disable blocks frames, current finishes
// [RULE11] Transmitter disable blocks frames, current finishes
// [RULE12] Bits 8 and 9 choose the port
// [RULE13] Twisted-pair transmitter needs link or test disable
// [RULE14] Modified backoff lengthens first three backoffs
// [RULE15] Polarity fix disable stops reversal correction
// [RULE16] Two-stage deferral unless its disable is set
// [RULE17] Link good clear after reset or 50 ms idle
// [RULE18] Status shows attachment or twisted-pair port use
// [RULE19] Polarity normal shows true incoming polarity
// [RULE20] Carrier drops 1.3 to 2.3 bits after data
// [RULE21] Line status low bits read 010100
// [RULE22] Increment during clear-on-read is kept
package lcs_pkg;
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned CLOCK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int unsigned LINK_FAIL_MS = 50;
    localparam int unsigned LINK_FAIL_CYCLES = (CLOCK_HZ / 1000) * LINK_FAIL_MS;
    localparam int unsigned BIT_TIME_NS = 100;
    localparam int unsigned CARRIER_HOLD_TENTHS = 16;
    localparam int unsigned CARRIER_HOLD_CYCLES =
        (BIT_TIME_NS * CARRIER_HOLD_TENTHS / 10) / CLK_PERIOD_NS;
    localparam int unsigned LINK_CNT_W = 22;
    localparam int unsigned HOLD_CNT_W = 4;
    // Register indices and byte addresses
    localparam int unsigned ADDR_W = 12;
    localparam logic [15:0] IDX_IRQ_CONFIG = 16'h010a;
    localparam logic [15:0] IDX_LINE_CONTROL = 16'h0112;
    localparam logic [15:0] IDX_LINK_TEST = 16'h0118;
    localparam logic [15:0] IDX_MISSED_FRAME = 16'h0130;
    localparam logic [15:0] IDX_COLLISION = 16'h0132;
    localparam logic [15:0] IDX_LINE_STATUS = 16'h0134;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CONFIG = ADDR_W'({IDX_IRQ_CONFIG, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_LINE_CONTROL = ADDR_W'({IDX_LINE_CONTROL, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_LINK_TEST = ADDR_W'({IDX_LINK_TEST, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_MISSED_FRAME = ADDR_W'({IDX_MISSED_FRAME, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_COLLISION = ADDR_W'({IDX_COLLISION, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = ADDR_W'({IDX_LINE_STATUS, 2'b00});
    // Reset values and writable masks
    localparam logic [15:0] RST_LINE_CONTROL = 16'h0013;
    localparam logic [15:0] RST_IRQ_CONFIG = 16'h000b;
    localparam logic [15:0] RST_LINK_TEST = 16'h0019;
    localparam logic [15:0] MASK_LINE_CONTROL = 16'h7bc0;
    localparam logic [15:0] MASK_IRQ_CONFIG = 16'h3000;
    localparam logic [15:0] MASK_LINK_TEST = 16'h0080;
    // Fixed identifying patterns in bits 5..0
    localparam logic [5:0] ID_MISSED_FRAME = 6'h10;
    localparam logic [5:0] ID_COLLISION = 6'h12;
    localparam logic [5:0] ID_LINE_STATUS = 6'h14;
    // Counter layout
    localparam int unsigned COUNT_W = 10;
    localparam int unsigned COUNT_LSB = 6;
    localparam logic [COUNT_W-1:0] COUNT_HALF = 10'h1ff;
    localparam logic [COUNT_W-1:0] COUNT_TOP = 10'h3ff;
    // Line control fields
    localparam int unsigned LC_RECEIVER_ENABLE = 6;
    localparam int unsigned LC_TRANSMITTER_ENABLE = 7;
    localparam int unsigned LC_ATTACHMENT_PORT_ONLY = 8;
    localparam int unsigned LC_AUTO_PORT_SELECT = 9;
    localparam int unsigned LC_MODIFIED_BACKOFF_ENABLE = 11;
    localparam int unsigned LC_POLARITY_FIX_DISABLE = 12;
    localparam int unsigned LC_TWO_STAGE_DEFERRAL_DISABLE = 13;
    localparam int unsigned LC_LOW_SQUELCH_SELECT = 14;
    // Interrupt configuration and link test fields
    localparam int unsigned IC_COLLISION_WRAP_IRQ_ENABLE = 12;
    localparam int unsigned IC_MISS_WRAP_IRQ_ENABLE = 13;
    localparam int unsigned LT_LINK_TEST_DISABLE = 7;
    // Line status fields
    localparam int unsigned LS_LINK_GOOD = 7;
    localparam int unsigned LS_ATTACHMENT_IN_USE = 8;
    localparam int unsigned LS_TWISTED_PAIR_IN_USE = 9;
    localparam int unsigned LS_POLARITY_NORMAL = 12;
    localparam int unsigned LS_CARRIER_ACTIVE = 14;
    // Synchronised pin positions
    localparam int unsigned PIN_COUNT = 5;
    localparam int unsigned PIN_RX_ACTIVE = 0;
    localparam int unsigned PIN_COLLISION = 1;
    localparam int unsigned PIN_LINK_PULSE = 2;
    localparam int unsigned PIN_RX_DATA = 3;
    localparam int unsigned PIN_POL_REVERSED = 4;
    // Port chosen for the line
    typedef enum logic {LCS_PORT_TWISTED_PAIR, LCS_PORT_ATTACHMENT} lcs_port_t;
endpackage
